// *** hw/lp_uart_map.svh ***
/*
  register offsets, field positions and reset values of the
  low-power serial transceiver; assumes inclusion by bare name
*/
`ifndef LP_UART_MAP_SVH
`define LP_UART_MAP_SVH
`define OFS_CONTROL_ONE 6'h00
`define OFS_CONTROL_TWO 6'h04
`define OFS_INTERRUPT_ENABLE 6'h10
`define OFS_INTERRUPT_FLAG_STATUS 6'h14
`define OFS_RECEIVE_DATA 6'h18
`define OFS_TRANSMIT_DATA 6'h1C
`define OFS_BAUD_DIVISOR 6'h20
`define OFS_BAUD_COMPENSATION 6'h24
`define OFS_RECEIVE_TIMEOUT_VALUE 6'h28
`define OFS_MATCH_CHARACTER 6'h2C
`define OFS_TRANSMIT_DELAY 6'h30
`define RST_FLAG_STATUS 32'h00000004
`define RST_BAUD_DIVISOR 16'hFFFF
`define RST_TIMEOUT_VALUE 16'hFFFF
// control_one fields
`define C1_BLOCK_ON 1
`define C1_WAKEUP_ON 2
`define C1_RECEIVER_ON 3
`define C1_TRANSMITTER_ON 4
`define C1_HALF_DUPLEX 5
`define C1_OVS_LO 6
`define C1_STOP_COUNT 8
`define C1_WIDTH_LO 10
`define C1_PARITY_TYPE 12
`define C1_STICK_PARITY 13
`define C1_PARITY_ON 14
// control_two fields
`define C2_TIMEOUT_ON 3
`define C2_MATCH_ON 4
`define C2_DRIVER_ON 6
`define C2_DRIVER_POL 7
`define C2_LAG_LO 8
`define C2_LEAD_LO 16
// status fields
`define ST_RX_NOT_EMPTY 0
`define ST_TX_COMPLETE 2
`define ST_START_DETECT 4
`define ST_TIMEOUT 6
`define ST_MATCH 7
`define ST_RX_BUSY 12
`define ST_PARITY_ERR 13
`define ST_FRAME_ERR 14
`define ST_OVERRUN 15
`endif

// *** hw/lp_uart_pkg.sv ***
/*
  types of the low-power serial transceiver; assumes nothing
*/
package lp_uart_pkg;
  typedef enum logic [1:0] {OVS_X16, OVS_X8, OVS_X1, OVS_RSVD} ovs_t;
  typedef enum {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_LAG} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : lp_uart_pkg

// *** hw/low_power_uart.sv ***
/*
  low-power asynchronous serial transceiver: register port, transmitter,
  receiver, driver-enable timing, match, timeout and wake request;
  assumes one clock serving both bus and serial kernel, synchronous pins
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "lp_uart_map.svh"
module low_power_uart (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [5:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_SERIAL_IN_PIN,
  input wire logic I_SERIAL_OUT_PIN_IN,
  output logic O_SERIAL_OUT_PIN,
  output logic O_SERIAL_OUT_PIN_OE,
  output logic O_LINE_DRIVER_PIN,
  output logic O_WAKEUP_REQ
);
  import lp_uart_pkg::*;

  logic [31:0] ctl1_ff, ctl2_ff, ien_ff, bcmp_ff, dly_ff;
  logic [15:0] bdiv_ff, tmo_val_ff;
  logic [7:0] match_ff, tdata_ff, rdata_ff;
  logic rxne_ff, txc_ff, sbd_ff, rto_ff, rcd_ff, pe_ff, fe_ff, dor_ff;
  logic tx_pend_ff;

  wire block_on = ctl1_ff[`C1_BLOCK_ON];
  wire half_dup = ctl1_ff[`C1_HALF_DUPLEX];
  wire par_on = ctl1_ff[`C1_PARITY_ON];
  wire par_type = ctl1_ff[`C1_PARITY_TYPE];
  wire stick_on = ctl1_ff[`C1_STICK_PARITY];
  wire two_stop = ctl1_ff[`C1_STOP_COUNT];
  wire [1:0] width_sel = ctl1_ff[`C1_WIDTH_LO +: 2];
  ovs_t ovs;
  assign ovs = ovs_t'(ctl1_ff[`C1_OVS_LO +: 2]);
  wire tx_run = block_on && ctl1_ff[`C1_TRANSMITTER_ON];
  wire rx_run = block_on && ctl1_ff[`C1_RECEIVER_ON];
  wire drv_on = ctl2_ff[`C2_DRIVER_ON];
  wire [4:0] lead_n = ctl2_ff[`C2_LEAD_LO +: 5];
  wire [4:0] lag_n = ctl2_ff[`C2_LAG_LO +: 5];

  // samples per bit
  function automatic logic [4:0] ratio(input ovs_t o);
    unique case (o)
      OVS_X16: ratio = 5'h10;
      OVS_X8: ratio = 5'h08;
      OVS_X1, OVS_RSVD: ratio = 5'h01;
    endcase
  endfunction : ratio

  function automatic logic [2:0] last_bit(input logic [1:0] w);
    last_bit = 3'(3'h4 + {1'b0, w});
  endfunction : last_bit

  // parity bit over the active data bits
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] w,
                                   input logic t, input logic s);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - w);
    if (s) par_bit = t;
    else par_bit = ^(d & m) ^ ~t;
  endfunction : par_bit

  // register writes
  wire wr_c1 = I_WR && I_ADDR == `OFS_CONTROL_ONE;
  wire wr_fs = I_WR && I_ADDR == `OFS_INTERRUPT_FLAG_STATUS;
  wire wr_td = I_WR && I_ADDR == `OFS_TRANSMIT_DATA;
  wire rd_rd = I_RD && I_ADDR == `OFS_RECEIVE_DATA;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctl1_ff <= 32'h00000000;
      ctl2_ff <= 32'h00000000;
      ien_ff <= 32'h00000000;
      bdiv_ff <= `RST_BAUD_DIVISOR;
      bcmp_ff <= 32'h00000000;
      tmo_val_ff <= `RST_TIMEOUT_VALUE;
      match_ff <= 8'h00;
      dly_ff <= 32'h00000000;
      tdata_ff <= 8'h00;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `OFS_CONTROL_ONE: ctl1_ff <= I_WDATA & 32'h00007DFE;
        `OFS_CONTROL_TWO: ctl2_ff <= I_WDATA & 32'h001F1FD8;
        `OFS_INTERRUPT_ENABLE: ien_ff <= I_WDATA & 32'h000000D5;
        `OFS_BAUD_DIVISOR: bdiv_ff <= I_WDATA[15:0];
        `OFS_BAUD_COMPENSATION: bcmp_ff <= I_WDATA & 32'h000081FF;
        `OFS_RECEIVE_TIMEOUT_VALUE: tmo_val_ff <= I_WDATA[15:0];
        `OFS_MATCH_CHARACTER: match_ff <= I_WDATA[7:0];
        `OFS_TRANSMIT_DELAY: dly_ff <= I_WDATA;
        `OFS_TRANSMIT_DATA: tdata_ff <= I_WDATA[7:0];
        default: ;
      endcase
    end
  end

  // transmitter
  tx_state_t tx_st_ff;
  logic [4:0] tx_sub_ff, tx_dly_ff;
  logic [2:0] tx_idx_ff;
  logic tx_stop2_ff, tx_line_ff, de_act_ff;
  logic [7:0] tx_sh_ff;
  logic tx_done;
  // transmit bit clock, held in phase until the start bit
  logic [15:0] tx_pre_ff;
  wire tx_tick = (tx_pre_ff == bdiv_ff);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) tx_pre_ff <= 16'h0000;
    else if (!tx_run || tx_tick || tx_st_ff == TX_LEAD) tx_pre_ff <= 16'h0000;
    else tx_pre_ff <= 16'(tx_pre_ff + 16'h0001);
  end
  wire tx_bit_end = tx_tick && (tx_sub_ff == 5'(ratio(ovs) - 5'h01));
  assign tx_done = (tx_st_ff == TX_STOP) && tx_bit_end && (tx_stop2_ff || !two_stop);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) tx_pend_ff <= 1'b0;
    else if (!block_on) tx_pend_ff <= 1'b0;
    else if (wr_td) tx_pend_ff <= 1'b1;
    else if (tx_st_ff == TX_IDLE && tx_run) tx_pend_ff <= 1'b0;
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_st_ff <= TX_IDLE;
      tx_sub_ff <= 5'h00;
      tx_dly_ff <= 5'h00;
      tx_idx_ff <= 3'h0;
      tx_stop2_ff <= 1'b0;
      tx_sh_ff <= 8'h00;
      tx_line_ff <= 1'b1;
      de_act_ff <= 1'b0;
    end else if (!tx_run) begin
      tx_st_ff <= TX_IDLE;
      tx_line_ff <= 1'b1;
      de_act_ff <= 1'b0;
      tx_sub_ff <= 5'h00;
    end else begin
      if (tx_tick && tx_st_ff inside {TX_START, TX_DATA, TX_PAR, TX_STOP})
        tx_sub_ff <= tx_bit_end ? 5'h00 : 5'(tx_sub_ff + 5'h01);
      unique case (tx_st_ff)
        TX_IDLE: if (tx_pend_ff) begin
          tx_sh_ff <= tdata_ff;
          tx_dly_ff <= lead_n;
          de_act_ff <= drv_on;
          tx_st_ff <= TX_LEAD;
        end
        TX_LEAD: if (tx_dly_ff == 5'h00) begin
          tx_st_ff <= TX_START;
          tx_line_ff <= 1'b0;
          tx_sub_ff <= 5'h00;
        end else tx_dly_ff <= 5'(tx_dly_ff - 5'h01);
        TX_START: if (tx_bit_end) begin
          tx_st_ff <= TX_DATA;
          tx_idx_ff <= 3'h0;
          tx_line_ff <= tx_sh_ff[0];
        end
        TX_DATA: if (tx_bit_end) begin
          if (tx_idx_ff == last_bit(width_sel)) begin
            tx_st_ff <= par_on ? TX_PAR : TX_STOP;
            tx_line_ff <= par_on ? par_bit(tx_sh_ff, width_sel, par_type, stick_on) : 1'b1;
            tx_stop2_ff <= 1'b0;
          end else begin
            tx_idx_ff <= 3'(tx_idx_ff + 3'h1);
            tx_line_ff <= tx_sh_ff[3'(tx_idx_ff + 3'h1)];
          end
        end
        TX_PAR: if (tx_bit_end) begin
          tx_st_ff <= TX_STOP;
          tx_line_ff <= 1'b1;
          tx_stop2_ff <= 1'b0;
        end
        TX_STOP: if (tx_bit_end) begin
          if (tx_done) begin
            tx_st_ff <= TX_LAG;
            tx_dly_ff <= lag_n;
          end else tx_stop2_ff <= 1'b1;
        end
        TX_LAG: if (tx_dly_ff == 5'h00) begin
          tx_st_ff <= TX_IDLE;
          de_act_ff <= 1'b0;
        end else tx_dly_ff <= 5'(tx_dly_ff - 5'h01);
      endcase
    end
  end
  wire tx_busy = tx_st_ff inside {TX_START, TX_DATA, TX_PAR, TX_STOP};

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SERIAL_OUT_PIN <= 1'b1;
      O_SERIAL_OUT_PIN_OE <= 1'b0;
      O_LINE_DRIVER_PIN <= 1'b0;
    end else begin
      O_SERIAL_OUT_PIN <= half_dup ? 1'b0 : tx_line_ff;
      // open drain in half duplex, released when idle
      O_SERIAL_OUT_PIN_OE <= half_dup ? (tx_busy && !tx_line_ff) : 1'b1;
      O_LINE_DRIVER_PIN <= (drv_on && de_act_ff) ^ ctl2_ff[`C2_DRIVER_POL];
    end
  end

  // receiver
  wire rx_line = half_dup ? (I_SERIAL_OUT_PIN_IN & tx_line_ff) : I_SERIAL_IN_PIN;
  rx_state_t rx_st_ff;
  logic [4:0] rx_sub_ff;
  logic [2:0] rx_idx_ff;
  logic [7:0] rx_sh_ff;
  logic rx_par_ff, rx_prev_ff, rx_stop_ff;
  // receive bit clock, re-phased to mid-bit at each start edge
  logic [15:0] pre_ff;
  wire tick = (pre_ff == bdiv_ff);
  wire [4:0] mid = ratio(ovs) >> 1;
  wire rx_samp = tick && rx_sub_ff == mid;
  wire rx_end = tick && rx_sub_ff == 5'(ratio(ovs) - 5'h01);
  wire start_edge = rx_run && rx_st_ff == RX_IDLE && rx_prev_ff && !rx_line;
  wire rx_load = rx_st_ff == RX_STOP && rx_samp;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) pre_ff <= 16'h0000;
    else if (!block_on) pre_ff <= 16'h0000;
    else if (start_edge) pre_ff <= 16'(bdiv_ff - (bdiv_ff >> 1));
    else if (tick) pre_ff <= 16'h0000;
    else pre_ff <= 16'(pre_ff + 16'h0001);
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_st_ff <= RX_IDLE;
      rx_sub_ff <= 5'h00;
      rx_idx_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_stop_ff <= 1'b1;
    end else if (!rx_run) begin
      rx_st_ff <= RX_IDLE;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_line;
      if (tick && rx_st_ff != RX_IDLE)
        rx_sub_ff <= rx_end ? 5'h00 : 5'(rx_sub_ff + 5'h01);
      unique case (rx_st_ff)
        RX_IDLE: if (start_edge) begin
          rx_st_ff <= RX_START;
          rx_sub_ff <= 5'h00;
        end
        RX_START: if (rx_samp && rx_line) rx_st_ff <= RX_IDLE;
          else if (rx_end) begin
            rx_st_ff <= RX_DATA;
            rx_idx_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
          end
        RX_DATA: begin
          if (rx_samp) rx_sh_ff[rx_idx_ff] <= rx_line;
          if (rx_end) begin
            if (rx_idx_ff == last_bit(width_sel)) rx_st_ff <= par_on ? RX_PAR : RX_STOP;
            else rx_idx_ff <= 3'(rx_idx_ff + 3'h1);
          end
        end
        RX_PAR: begin
          if (rx_samp) rx_par_ff <= rx_line;
          if (rx_end) rx_st_ff <= RX_STOP;
        end
        RX_STOP: if (rx_samp) begin
          rx_stop_ff <= rx_line;
          rx_st_ff <= RX_IDLE;
        end
      endcase
    end
  end
  wire perr = par_on && (rx_par_ff != par_bit(rx_sh_ff, width_sel, par_type, stick_on));
  wire ferr = !rx_line;

  // timeout counter, one step per bit
  logic [15:0] tmo_ff;
  logic tmo_run_ff;
  logic [4:0] bt_ff;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) bt_ff <= 5'h00;
    else if (tick) bt_ff <= (bt_ff == 5'(ratio(ovs) - 5'h01)) ? 5'h00 : 5'(bt_ff + 5'h01);
  end
  wire tmo_step = tick && bt_ff == 5'h00;
  wire tmo_under = tmo_run_ff && tmo_step && tmo_ff == 16'h0000;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tmo_ff <= 16'h0000;
      tmo_run_ff <= 1'b0;
    end else if (!rx_run || !ctl2_ff[`C2_TIMEOUT_ON]) tmo_run_ff <= 1'b0;
    else if (start_edge) begin
      tmo_ff <= tmo_val_ff;
      tmo_run_ff <= 1'b1;
    end else if (tmo_under) tmo_run_ff <= 1'b0;
    else if (tmo_run_ff && tmo_step) tmo_ff <= 16'(tmo_ff - 16'h0001);
  end

  // status flags: set wins over software clear
  wire [31:0] clr = wr_fs ? I_WDATA : 32'h00000000;
  wire good = rx_load && !perr && !ferr;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rxne_ff <= 1'b0;
      txc_ff <= 1'(`RST_FLAG_STATUS >> `ST_TX_COMPLETE);
      sbd_ff <= 1'b0;
      rto_ff <= 1'b0;
      rcd_ff <= 1'b0;
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
      dor_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (!block_on) begin
      rxne_ff <= 1'b0;
      txc_ff <= 1'b1;
      {sbd_ff, rto_ff, rcd_ff, pe_ff, fe_ff, dor_ff} <= 6'h00;
    end else begin
      if (rx_load && !rxne_ff && !dor_ff) begin
        rdata_ff <= rx_sh_ff;
        rxne_ff <= 1'b1;
      end else if (rd_rd || clr[`ST_RX_NOT_EMPTY]) rxne_ff <= 1'b0;
      if (rx_load && rxne_ff) dor_ff <= 1'b1;
      else if (clr[`ST_OVERRUN]) dor_ff <= 1'b0;
      if (rx_load) pe_ff <= perr;
      else if (clr[`ST_PARITY_ERR]) pe_ff <= 1'b0;
      if (rx_load) fe_ff <= ferr;
      else if (clr[`ST_FRAME_ERR]) fe_ff <= 1'b0;
      if (good && ctl2_ff[`C2_MATCH_ON] && rx_sh_ff == match_ff) rcd_ff <= 1'b1;
      else if (clr[`ST_MATCH]) rcd_ff <= 1'b0;
      if (tmo_under) rto_ff <= 1'b1;
      else if (clr[`ST_TIMEOUT]) rto_ff <= 1'b0;
      if (start_edge && ctl1_ff[`C1_WAKEUP_ON]) sbd_ff <= 1'b1;
      else if (clr[`ST_START_DETECT]) sbd_ff <= 1'b0;
      if (tx_done) txc_ff <= 1'b1;
      else if (clr[`ST_TX_COMPLETE] || wr_td) txc_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) O_WAKEUP_REQ <= 1'b0;
    else O_WAKEUP_REQ <= ctl1_ff[`C1_WAKEUP_ON] && block_on &&
      ((sbd_ff && ien_ff[`ST_START_DETECT]) || (rxne_ff && ien_ff[`ST_RX_NOT_EMPTY]) ||
       (rcd_ff && ien_ff[`ST_MATCH]));
  end

  // read port, data one cycle after strobe
  logic [31:0] status;
  always_comb begin
    status = 32'h00000000;
    status[`ST_RX_NOT_EMPTY] = rxne_ff;
    status[`ST_TX_COMPLETE] = txc_ff;
    status[`ST_START_DETECT] = sbd_ff;
    status[`ST_TIMEOUT] = rto_ff;
    status[`ST_MATCH] = rcd_ff;
    status[`ST_RX_BUSY] = rx_st_ff != RX_IDLE;
    status[`ST_PARITY_ERR] = pe_ff;
    status[`ST_FRAME_ERR] = fe_ff;
    status[`ST_OVERRUN] = dor_ff;
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) O_RDATA <= 32'h00000000;
    else if (I_RD) begin
      unique case (I_ADDR)
        `OFS_CONTROL_ONE: O_RDATA <= ctl1_ff;
        `OFS_CONTROL_TWO: O_RDATA <= ctl2_ff;
        `OFS_INTERRUPT_ENABLE: O_RDATA <= ien_ff;
        `OFS_INTERRUPT_FLAG_STATUS: O_RDATA <= status;
        `OFS_RECEIVE_DATA: O_RDATA <= {24'h000000, rdata_ff};
        `OFS_TRANSMIT_DATA: O_RDATA <= {24'h000000, tdata_ff};
        `OFS_BAUD_DIVISOR: O_RDATA <= {16'h0000, bdiv_ff};
        `OFS_BAUD_COMPENSATION: O_RDATA <= bcmp_ff;
        `OFS_RECEIVE_TIMEOUT_VALUE: O_RDATA <= {16'h0000, tmo_val_ff};
        `OFS_MATCH_CHARACTER: O_RDATA <= {24'h000000, match_ff};
        `OFS_TRANSMIT_DELAY: O_RDATA <= dly_ff;
        default: O_RDATA <= 32'h00000000;
      endcase
    end else O_RDATA <= 32'h00000000;
  end
endmodule : low_power_uart

// *** verif/lp_uart_chk.sv ***
/*
  port checker of the low-power serial transceiver;
  assumes the bind below and one clock for bus and kernel
*/
`timescale 1ns/1ps
`include "lp_uart_map.svh"
module lp_uart_chk (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [5:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic I_SERIAL_IN_PIN,
  input wire logic I_SERIAL_OUT_PIN_IN,
  input wire logic O_SERIAL_OUT_PIN,
  input wire logic O_SERIAL_OUT_PIN_OE,
  input wire logic O_LINE_DRIVER_PIN,
  input wire logic O_WAKEUP_REQ
);
  logic [31:0] c1_ff;
  logic [31:0] c2_ff;
  logic tx_run;
  // shadow copies of the two control words
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      c1_ff <= 32'h0;
    end else if (I_WR && I_ADDR == `OFS_CONTROL_ONE) begin
      c1_ff <= I_WDATA;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      c2_ff <= 32'h0;
    end else if (I_WR && I_ADDR == `OFS_CONTROL_TWO) begin
      c2_ff <= I_WDATA;
    end
  end
  assign tx_run = c1_ff[`C1_BLOCK_ON] && c1_ff[`C1_TRANSMITTER_ON];
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_bit_low;
    !O_SERIAL_OUT_PIN [*3];
  endsequence
  a_bit_len: assert property ($fell(O_SERIAL_OUT_PIN) && !c1_ff[5] |=> s_bit_low)
    else $error("low bit shorter than four cycles");
  a_de_frame: assert property (!O_SERIAL_OUT_PIN && O_SERIAL_OUT_PIN_OE && c2_ff[6]
    |-> O_LINE_DRIVER_PIN == !c2_ff[7])
    else $error("driver not active while line driven low");
  a_de_off: assert property (!c2_ff[6] && !$past(c2_ff[6]) && $stable(c2_ff[7])
    |-> O_LINE_DRIVER_PIN == c2_ff[7])
    else $error("driver active with function off");
  a_wake_gate: assert property (O_WAKEUP_REQ |-> $past(c1_ff[2]) && $past(c1_ff[1]))
    else $error("wake request without wake and block enable");
  a_hd_drive: assert property (c1_ff[5] && $past(c1_ff[5]) && O_SERIAL_OUT_PIN_OE
    |-> !O_SERIAL_OUT_PIN)
    else $error("half duplex pin driven high");
  a_tx_idle: assert property (!tx_run && !$past(tx_run) && !$past(tx_run, 2)
    && !c1_ff[5] && !$past(c1_ff[5]) |-> O_SERIAL_OUT_PIN)
    else $error("line left idle level with transmitter off");
  a_rd_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data outside answer cycle");
  a_rd_unmapped: assert property (I_RD && I_ADDR == 6'h3C |=> O_RDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule : lp_uart_chk
bind low_power_uart lp_uart_chk u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_SERIAL_IN_PIN(I_SERIAL_IN_PIN), .I_SERIAL_OUT_PIN_IN(I_SERIAL_OUT_PIN_IN),
  .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN), .O_SERIAL_OUT_PIN_OE(O_SERIAL_OUT_PIN_OE),
  .O_LINE_DRIVER_PIN(O_LINE_DRIVER_PIN), .O_WAKEUP_REQ(O_WAKEUP_REQ));

// *** verif/uart_far_end.sv ***
/*
  remote serial station: sends frames on request, captures frames seen;
  assumes the bench sets bit length and captured bit count
*/
`timescale 1ns/1ps
module uart_far_end (
  input wire logic i_clk,
  input wire logic i_line,
  input var int i_bit,
  input var int i_n,
  output logic o_line
);
  logic [11:0] cap = 12'hFFF;
  int got = 0;
  initial o_line = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    o_line <= 1'b0;
    repeat (i_bit) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= f[i];
      repeat (i_bit) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask : send
  // mid-bit sampling after each falling edge
  always begin
    @(negedge i_line);
    cap = 12'hFFF;
    repeat (i_bit / 2) @(posedge i_clk);
    for (int i = 0; i < i_n; i++) begin
      repeat (i_bit) @(posedge i_clk);
      #1 cap[i] = i_line;
    end
    got++;
  end
endmodule : uart_far_end

// *** verif/tb.sv ***
/*
  self-checking bench of the low-power serial transceiver;
  assumes the design, its map header and the remote station model
*/
`timescale 1ns/1ps
`include "lp_uart_map.svh"
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic ser_out;
  logic ser_oe;
  logic drv;
  logic wake;
  logic rx_line;
  wire tx_wire = !(ser_oe && !ser_out);
  int bit_cyc = 4;
  int far_n = 10;
  int err_total = 0;
  int n_checks = 0;
  int lead_t[3] = '{0, 20, 31};
  int lag_t[3] = '{0, 12, 31};
  logic [31:0] seed = 32'h3CB6;
  logic pol = 1'b0;
  logic [31:0] c1;
  low_power_uart u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SERIAL_IN_PIN(rx_line),
    .I_SERIAL_OUT_PIN_IN(tx_wire), .O_SERIAL_OUT_PIN(ser_out), .O_SERIAL_OUT_PIN_OE(ser_oe),
    .O_LINE_DRIVER_PIN(drv), .O_WAKEUP_REQ(wake));
  uart_far_end u_far (.i_clk(clk), .i_line(tx_wire), .i_bit(bit_cyc), .i_n(far_n),
    .o_line(rx_line));
  // bus and kernel share this one clock
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // bits after the start bit, count in the top nibble
  function automatic logic [15:0] frame(input logic [7:0] d, input logic [31:0] c);
    int n = c[11:10] + 5;
    logic [11:0] f = 12'hFFF;
    logic x = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[i] = d[i];
      x ^= d[i];
    end
    if (c[14]) begin
      f[n] = c[13] ? c[12] : (c[12] ? x : !x);
      n++;
    end
    n += c[8] ? 2 : 1;
    return {n[3:0], f};
  endfunction : frame
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_up();
    err_total++;
    print_verdict();
  endtask : give_up
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_reg(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask : chk_reg
  task automatic wait_st(input int b);
    logic [31:0] s = 32'h0;
    int k = 0;
    while (s[b] !== 1'b1 && k < 1000) begin
      rd_reg(`OFS_INTERRUPT_FLAG_STATUS, s);
      k++;
    end
    if (k >= 1000) give_up();
  endtask : wait_st
  // send one character, count driver cycles before start and in total
  task automatic xmit(input logic [7:0] d, output int lead, output int on);
    int k = 0;
    int g = u_far.got;
    bit seen = 1'b0;
    lead = 0;
    on = 0;
    wr_reg(`OFS_TRANSMIT_DATA, {24'h0, d});
    while ((g == u_far.got || (drv ^ pol)) && k < 3000) begin
      @(posedge clk);
      #1 k++;
      on += (drv ^ pol);
      lead += (drv ^ pol) && !seen && tx_wire;
      seen |= !tx_wire;
    end
    if (k >= 3000) give_up();
  endtask : xmit
  task automatic recv(input logic [7:0] d, input logic [31:0] c, input logic flip);
    logic [15:0] f = frame(d, c);
    @(posedge clk);
    u_far.send(f[11:0] ^ ({11'h0, flip} << (c[11:10] + 5)), int'(f[15:12]));
  endtask : recv
  initial begin
    logic [31:0] v;
    logic [15:0] f;
    logic [7:0] d;
    int l0 = 0;
    int o0 = 0;
    int l;
    int o;
    int g;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk_reg(`OFS_INTERRUPT_FLAG_STATUS, `RST_FLAG_STATUS);
    chk_reg(`OFS_BAUD_DIVISOR, 32'h0000FFFF);
    chk_reg(`OFS_RECEIVE_TIMEOUT_VALUE, 32'h0000FFFF);
    chk_reg(`OFS_CONTROL_ONE, 32'h0);
    wr_reg(6'h3C, 32'hFFFFFFFF);
    chk_reg(6'h3C, 32'h0);
    wr_reg(`OFS_BAUD_DIVISOR, 32'h3);
    // random formats, every oversample code, both directions
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'h00 : seed[23:16];
      c1 = 32'h1A | (seed & 32'h7D00) | ((i % 4) << 6);
      bit_cyc = (i % 4 == 0) ? 64 : (i % 4 == 1) ? 32 : 4;
      wr_reg(`OFS_CONTROL_ONE, c1);
      f = frame(d, c1);
      far_n = int'(f[15:12]);
      xmit(d, l, o);
      chk({20'h0, u_far.cap}, {20'h0, f[11:0]});
      recv(d, c1, 1'b0);
      wait_st(`ST_RX_NOT_EMPTY);
      chk_reg(`OFS_RECEIVE_DATA, d & ((32'h1 << (c1[11:10] + 5)) - 1));
      rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
      chk(v & 32'h2001, 32'h0);
    end
    bit_cyc = 4;
    c1 = 32'h5C9A;
    wr_reg(`OFS_CONTROL_ONE, c1);
    recv(8'hA5, c1, 1'b1);
    wait_st(`ST_RX_NOT_EMPTY);
    rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
    chk({31'h0, v[`ST_PARITY_ERR]}, 32'h1);
    recv(8'h3C, c1, 1'b0);
    wait_st(`ST_OVERRUN);
    chk_reg(`OFS_RECEIVE_DATA, 32'hA5);
    wr_reg(`OFS_INTERRUPT_FLAG_STATUS, 32'hA000);
    rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
    chk(v & 32'hA001, 32'h0);
    c1 = 32'h0C9A;
    wr_reg(`OFS_CONTROL_ONE, c1);
    far_n = 9;
    for (int j = 0; j < 3; j++) begin
      pol = (j == 1);
      wr_reg(`OFS_CONTROL_TWO, 32'h40 | (pol << 7) | (lag_t[j] << 8) | (lead_t[j] << 16));
      xmit(8'h5A, l, o);
      l0 = (j == 0) ? l : l0;
      o0 = (j == 0) ? o : o0;
      chk(32'(l - l0), 32'(lead_t[j]));
      chk(32'(o - o0), 32'(lead_t[j] + lag_t[j]));
    end
    rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
    chk({31'h0, v[`ST_TX_COMPLETE]}, 32'h1);
    wr_reg(`OFS_INTERRUPT_FLAG_STATUS, 32'h4);
    rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
    chk({31'h0, v[`ST_TX_COMPLETE]}, 32'h0);
    // abort in the lead phase
    g = u_far.got;
    wr_reg(`OFS_CONTROL_TWO, 32'h001F0040);
    wr_reg(`OFS_TRANSMIT_DATA, 32'h33);
    wr_reg(`OFS_CONTROL_ONE, 32'h0C98);
    chk_reg(`OFS_INTERRUPT_FLAG_STATUS, `RST_FLAG_STATUS);
    chk_reg(`OFS_CONTROL_ONE, 32'h0C98);
    repeat (100) @(posedge clk);
    chk(32'(u_far.got), 32'(g));
    // wake armed just before use and cleared after
    wr_reg(`OFS_CONTROL_TWO, 32'h18);
    wr_reg(`OFS_MATCH_CHARACTER, 32'h6E);
    wr_reg(`OFS_RECEIVE_TIMEOUT_VALUE, 32'h6);
    wr_reg(`OFS_INTERRUPT_ENABLE, 32'h1);
    c1 = 32'h0C9E;
    wr_reg(`OFS_CONTROL_ONE, c1);
    recv(8'h6E, c1, 1'b0);
    wait_st(`ST_MATCH);
    chk({31'h0, wake}, 32'h1);
    wait_st(`ST_TIMEOUT);
    wr_reg(`OFS_CONTROL_ONE, 32'h0C9A);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, wake}, 32'h0);
    chk_reg(`OFS_RECEIVE_DATA, 32'h6E);
    wr_reg(`OFS_CONTROL_TWO, 32'h0);
    c1 = 32'h0CBA;
    wr_reg(`OFS_CONTROL_ONE, c1);
    f = frame(8'hC3, c1);
    xmit(8'hC3, l, o);
    chk({20'h0, u_far.cap}, {20'h0, f[11:0]});
    wait_st(`ST_RX_NOT_EMPTY);
    chk_reg(`OFS_RECEIVE_DATA, 32'hC3);
    // both units off
    c1 = 32'h0C82;
    wr_reg(`OFS_CONTROL_ONE, c1);
    g = u_far.got;
    wr_reg(`OFS_TRANSMIT_DATA, 32'h55);
    recv(8'h77, c1, 1'b0);
    repeat (50) @(posedge clk);
    chk(32'(u_far.got), 32'(g));
    rd_reg(`OFS_INTERRUPT_FLAG_STATUS, v);
    chk({31'h0, v[`ST_RX_NOT_EMPTY]}, 32'h0);
    print_verdict();
  end
endmodule : tb
